// *** hdl/strap_consts.svh ***
// timing constants and reset values for the reset and test-strap block
`ifndef STRAP_CONSTS_SVH
`define STRAP_CONSTS_SVH
`define CLK_PERIOD_NS        40
`define STRAP_DELAY_NS       1500
`define STRAP_DELAY_CYCLES   ((`STRAP_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STRAP_WIDTH          8
`define STRAP_MODE_RESET     8'h00
`define TEST_OUT_RESET       8'h00
`define CONFIG_DONE_RESET    1'b0
`endif

// *** hdl/strap_pkg.sv ***
// types shared by the reset and test-strap block
`default_nettype none
package strap_pkg;
	typedef enum logic [3:0] {
		ST_HELD   = 4'b0001,
		ST_WAIT   = 4'b0010,
		ST_SAMPLE = 4'b0100,
		ST_RUN    = 4'b1000
	} seq_state_t;

	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} strap_drive_t;
endpackage
`default_nettype wire

// *** hdl/sync2.sv ***
// two-flop synchroniser for pin inputs, parameterised width
`default_nettype none
module sync2 #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] din,
	output var  logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] stage1;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= '0;
			dout   <= '0;
		end else begin
			stage1 <= din;
			dout   <= stage1;
		end
	end
endmodule
`default_nettype wire

// *** hdl/reset_and_test_strap_sampling.sv ***
// reset release sequencing and test-strap sampling for the controller
`include "strap_consts.svh"
`default_nettype none
module reset_and_test_strap_sampling
	import strap_pkg::*;
#(
	parameter int STRAP_WIDTH  = `STRAP_WIDTH,
	parameter int DELAY_CYCLES = `STRAP_DELAY_CYCLES
) (
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire logic                   power_on_reset_low,
	input  wire logic [STRAP_WIDTH-1:0] test_strap_pin_in,
	output var  logic [STRAP_WIDTH-1:0] test_strap_pin_out,
	output var  logic [STRAP_WIDTH-1:0] test_strap_pin_oe,
	input  wire logic [STRAP_WIDTH-1:0] test_out_data,
	output var  logic [STRAP_WIDTH-1:0] test_mode_select,
	output var  logic                   test_mode_active,
	output var  logic                   config_start,
	output var  logic                   config_done
);
	localparam int CW = $clog2(DELAY_CYCLES + 1);
	localparam logic [CW-1:0] LAST_COUNT = CW'(DELAY_CYCLES - 1);
	// reset values widened here so a non-default strap width still lines up
	localparam logic [STRAP_WIDTH-1:0] MODE_RESET = STRAP_WIDTH'(`STRAP_MODE_RESET);
	localparam logic [STRAP_WIDTH-1:0] OUT_RESET  = STRAP_WIDTH'(`TEST_OUT_RESET);

	logic                   por_sync;
	logic                   por_prev;
	logic [STRAP_WIDTH-1:0] strap_sync;

	logic [CW-1:0]          wait_count;
	logic                   wait_done;
	seq_state_t             state;
	seq_state_t             next_state;

	logic                   held;
	logic                   release_edge;
	logic                   sample_now;
	logic                   drive_phase;
	logic                   strap_taken;

	// reset pin is asynchronous to clk: two flops before any logic looks at it
	sync2 #(
		.WIDTH (1)
	) u_por_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.din   (power_on_reset_low),
		.dout  (por_sync)
	);

	// strap levels arrive from the board; same two-flop treatment
	sync2 #(
		.WIDTH (STRAP_WIDTH)
	) u_strap_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.din   (test_strap_pin_in),
		.dout  (strap_sync)
	);

	// low level on the synchronised pin means reset asserted
	assign held = ~por_sync;

	// a release is the first cycle the synchronised pin reads high after reading low
	assign release_edge = por_sync && !por_prev;

	// the settling wait ends on the last count, one cycle before the sample
	assign wait_done = wait_count == LAST_COUNT;

	// strap capture happens in the single sample cycle, never while reset is seen
	assign sample_now = !held && state == ST_SAMPLE && !strap_taken;

	// pins, done flag and drive data all switch together on entry to the run phase
	assign drive_phase = !held && next_state == ST_RUN;

	// starts low so a pin already high when the system reset lifts still counts as a release
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			por_prev <= 1'b0;
		end else begin
			por_prev <= por_sync;
		end
	end

	always_comb begin
		next_state = state;
		case (state)
			ST_HELD: begin
				if (release_edge) begin
					next_state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (wait_done) begin
					next_state = ST_SAMPLE;
				end
			end
			ST_SAMPLE: begin
				next_state = ST_RUN;
			end
			ST_RUN: begin
				next_state = ST_RUN;
			end
			default: begin
				// a corrupted one-hot code falls back to held and waits for a fresh release
				next_state = ST_HELD;
			end
		endcase
		// a reset seen in any state overrides the walk above
		if (held) begin
			next_state = ST_HELD;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_HELD;
		end else begin
			state <= next_state;
		end
	end

	// delay counts from the release edge; restarts on every new release
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_count <= '0;
		end else if (state == ST_WAIT && !held) begin
			wait_count <= wait_count + CW'(1);
		end else begin
			wait_count <= '0;
		end
	end

	// marks that this release has already been sampled; only a seen reset clears it,
	// so a stray second pass through the sample state cannot re-latch the straps
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_taken <= 1'b0;
		end else if (held) begin
			strap_taken <= 1'b0;
		end else if (sample_now) begin
			strap_taken <= 1'b1;
		end
	end

	// selection captured once per release and cleared only by reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			test_mode_select <= MODE_RESET;
		end else if (held) begin
			test_mode_select <= MODE_RESET;
		end else if (sample_now) begin
			test_mode_select <= strap_sync;
		end
	end

	// any pin pulled high at the sampling instant selects a test mode
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			test_mode_active <= 1'b0;
		end else if (held) begin
			test_mode_active <= 1'b0;
		end else if (sample_now) begin
			test_mode_active <= |strap_sync;
		end
	end

	// pins stay released to high impedance until sampling is complete; the two-flop
	// lag means they let go a few cycles after the reset pin falls, not at once
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			test_strap_pin_oe <= '0;
		end else if (drive_phase) begin
			test_strap_pin_oe <= '1;
		end else begin
			test_strap_pin_oe <= '0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			test_strap_pin_out <= OUT_RESET;
		end else if (drive_phase) begin
			test_strap_pin_out <= test_out_data;
		end else begin
			test_strap_pin_out <= OUT_RESET;
		end
	end

	// one-cycle pulse marking the detected release edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			config_start <= 1'b0;
		end else begin
			config_start <= state == ST_HELD && release_edge;
		end
	end

	// level flag for the run phase; drops together with the pin enables when reset
	// is seen again, so nothing downstream sees a half-configured controller
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			config_done <= `CONFIG_DONE_RESET;
		end else begin
			config_done <= drive_phase;
		end
	end
endmodule
`default_nettype wire

// *** tb/strap_checker.sv ***
// port assertions for the reset and test-strap block
`default_nettype none
module strap_checker #(
	parameter int DELAY_CYCLES = 38
) (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       power_on_reset_low,
	input wire logic [7:0] test_strap_pin_out,
	input wire logic [7:0] test_strap_pin_oe,
	input wire logic [7:0] test_out_data,
	input wire logic [7:0] test_mode_select,
	input wire logic       test_mode_active,
	input wire logic       config_start,
	input wire logic       config_done
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int LO = DELAY_CYCLES;
	localparam int HI = DELAY_CYCLES + 3;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// four low cycles cover the two-flop lag plus the clearing edge
	property p_quiet; !power_on_reset_low [*4] |-> !(config_start || config_done || test_mode_active); endproperty
	a_quiet: assert property (p_quiet) else $error("output active in reset");
	property p_hiz; !power_on_reset_low [*4] |-> test_strap_pin_oe == 8'h00 && test_mode_select == 8'h00; endproperty
	a_hiz: assert property (p_hiz) else $error("pins driven in reset");
	property p_start; config_start |-> $past(power_on_reset_low, 2) ##1 !config_start; endproperty
	a_start: assert property (p_start) else $error("start without release");
	// the run phase must begin inside the window, not merely be standing there already
	property p_when;
		config_start |-> ##[LO:HI] ($rose(config_done) || !power_on_reset_low);
	endproperty
	a_when: assert property (p_when) else $error("sample late");
	property p_drive;
		config_done |-> test_strap_pin_oe == 8'hff && test_strap_pin_out == $past(test_out_data);
	endproperty
	a_drive: assert property (p_drive) else $error("pins not driven");
	property p_mode; config_done |-> test_mode_active == (test_mode_select != 8'h00); endproperty
	a_mode: assert property (p_mode) else $error("mode flag wrong");
	property p_hold; config_done && $past(config_done) |-> $stable(test_mode_select); endproperty
	a_hold: assert property (p_hold) else $error("selection moved");
	c_test: cover property ($rose(config_done) && test_mode_active);
	c_norm: cover property ($rose(config_done) && !test_mode_active);
	c_abort: cover property (config_start ##3 !power_on_reset_low);
endmodule
bind reset_and_test_strap_sampling strap_checker #(
	.DELAY_CYCLES (DELAY_CYCLES)
) chk (
	.clk                (clk),
	.rst_n              (rst_n),
	.power_on_reset_low (power_on_reset_low),
	.test_strap_pin_out (test_strap_pin_out),
	.test_strap_pin_oe  (test_strap_pin_oe),
	.test_out_data      (test_out_data),
	.test_mode_select   (test_mode_select),
	.test_mode_active   (test_mode_active),
	.config_start       (config_start),
	.config_done        (config_done)
);
`default_nettype wire

// *** tb/pmic_model.sv ***
// power controller model that owns the reset pin
`default_nettype none
module pmic_model (
	input  wire logic clk,
	input  wire logic supplies_ok,
	output var  logic power_on_reset_low
);
	timeunit 1ns;
	timeprecision 1ns;
	initial power_on_reset_low = 1'b0;
	// released only once rails report stable; a sag pulls it low again on the next falling clock edge
	always @(negedge clk) power_on_reset_low <= supplies_ok;
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the reset and test-strap block
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk = 0, rst_n = 0, ok = 0, act, start, done;
	logic [7:0] strap = 8'h00, data = 8'h3c, pout, oe, sel;
	wire logic  por;
	wire logic [7:0] pin = (oe & pout) | (~oe & strap);
	int         err_count = 0, check_count = 0, cyc = 0;
	always #20 clk = ~clk;
	pmic_model pm (.clk(clk), .supplies_ok(ok), .power_on_reset_low(por));
	reset_and_test_strap_sampling #(.DELAY_CYCLES(4)) DUT (.clk(clk), .rst_n(rst_n), .power_on_reset_low(por),
		.test_strap_pin_in(pin), .test_strap_pin_out(pout), .test_strap_pin_oe(oe), .test_out_data(data),
		.test_mode_select(sel), .test_mode_active(act), .config_start(start), .config_done(done));
	task chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// ok changes by non-blocking assignment so the model reads it race-free on the same edge
	task power_cycle(input logic [7:0] s);
		int pulses;
		pulses = 0;
		strap = s;
		ok <= 1'b0;
		repeat (6) @(negedge clk);
		chk(oe, 8'h00);
		chk(sel | {7'h00, done | act}, 8'h00);
		ok <= 1'b1;
		repeat (20) if (done !== 1'b1) begin
			@(negedge clk);
			pulses += int'(start === 1'b1);
		end
		chk(pulses[7:0], 8'h01);
	endtask
	task normal_boot;
		power_cycle(8'h00);
		chk(oe, 8'hff);
		chk(pout, data);
		chk(sel | {7'h00, act}, 8'h00);
	endtask
	task test_boot;
		power_cycle(8'h81);
		chk({7'h00, act}, 8'h01);
		strap = 8'h00;
		data = 8'hc5;
		repeat (3) @(negedge clk);
		chk(sel, 8'h81);
		chk(pout, 8'hc5);
	endtask
	task aborted_boot;
		power_cycle(8'h02);
		ok <= 1'b0;
		repeat (2) @(negedge clk);
		ok <= 1'b1;
		repeat (3) @(negedge clk);
		ok <= 1'b0;
		repeat (12) @(negedge clk);
		chk({oe[0], done, 6'h00}, 8'h00);
		chk(sel, 8'h00);
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// caps the run at 1000 cycles; a boot that never completes only fails the check, since power_cycle waits at most 20 cycles
	always @(posedge clk) if (++cyc == 1000) begin
		err_count++;
		final_report();
	end
	initial begin
		repeat (5) @(negedge clk);
		rst_n = 1;
		normal_boot();
		test_boot();
		aborted_boot();
		normal_boot();
		final_report();
	end
endmodule
`default_nettype wire
